/* File: pkg/sbe_pkg.sv */
// constants shared by the sample block emitter and its testbench
// assumes a 100 MHz ref_clk and a separate link clock at the word rate
package sbe_pkg;

   // ==========================================================
   // clocking and timing
   localparam int REF_PERIOD_NS  = 10;      // ref_clk period
   localparam int LINK_RATE_MHZ  = 16;      // word rate on the link
   localparam int FIRST_WORD_NS  = 1100;    // trigger edge to first word
   localparam int DVALID_END_NS  = 1600;    // trigger edge to end of block
   localparam int MAX_TRIG_KHZ   = 500;     // fastest trigger the block sustains
   localparam int SYS_FAST_MHZ   = 80;      // board system clocks the timing
   localparam int SYS_MID_MHZ    = 32;      // figures were estimated from
   localparam int SYS_SLOW_HZ    = 20;
   // about-times: round down to whole ref_clk cycles
   localparam int FIRST_WORD_CYC = FIRST_WORD_NS / REF_PERIOD_NS;
   localparam int DVALID_END_CYC = DVALID_END_NS / REF_PERIOD_NS;
   localparam int MIN_TRIG_CYC   = (1000000 / MAX_TRIG_KHZ) / REF_PERIOD_NS;

   // ==========================================================
   // block layout
   localparam int          WORD_W      = 32;
   localparam int          BLOCK_WORDS = 8;
   localparam int          IDX_W       = 3;
   localparam logic [2:0]  LAST_IDX    = 3'h7;
   localparam logic [31:0] HEADER_WORD = 32'h0000_5a5a;  // arbitrary marker value

   // ==========================================================
   // register port
   localparam int         ADDR_W       = 4;
   localparam logic [3:0] CTRL_OFS     = 4'h0;
   localparam logic [3:0] STATUS_OFS   = 4'h4;
   localparam logic [3:0] COUNT_OFS    = 4'h8;
   localparam int         CTRL_EN_BIT  = 0;   // trigger acceptance enable
   localparam int         CTRL_CLR_BIT = 1;   // write one: clear block counter
   localparam logic       CTRL_EN_RST  = 1'b1;
   localparam int         ST_BUSY_BIT  = 0;
   localparam int         ST_SPARE_BIT = 1;
   localparam int         ST_FRAME_BIT = 2;
   localparam int         ST_CLR_BIT   = 3;
   localparam int         ST_SRC_BIT   = 4;
   localparam int         ST_DROP_BIT  = 5;   // sticky: trigger came while busy

   // ==========================================================
   // synchronised pin bundle positions
   localparam int PIN_W       = 8;
   localparam int PIN_TRIG_FP = 0;
   localparam int PIN_TRIG_IO = 1;
   localparam int PIN_RST_FP  = 2;
   localparam int PIN_RST_IO  = 3;
   localparam int PIN_SPARE   = 4;
   localparam int PIN_FRAME   = 5;
   localparam int PIN_CLR     = 6;
   localparam int PIN_SRC     = 7;

   // state encodings
   typedef enum logic [2:0] {
      RF_IDLE = 3'b001,
      RF_WAIT = 3'b010,
      RF_SEND = 3'b100
   } sbe_ref_state_t;

   typedef enum logic [1:0] {
      LK_IDLE = 2'b01,
      LK_SEND = 2'b10
   } sbe_link_state_t;

endpackage : sbe_pkg

/* File: logic/sbe_sync2.sv */
// two flip-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level or a toggle; no bus coherence given
module sbe_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : sbe_sync2

/* File: logic/sbe_emitter.sv */
// sample block emitter: one eight-word block on the link per trigger edge accepted while idle and enabled
// assumes ref_clk 100 MHz, link_clk at the word rate, straps as pin levels
//
// How it works
// - spare strap open reads one, fitted zero
// - words leave on link clock, 16 MHz
// - one 8-word block per trigger, 500 kHz
// - first word about 1100 ns after trigger
// - data valid ends about 1600 ns after
// - timing derived from the system clock figures
// - frame strap zero marks last word sync
// - clear strap fitted adds reset pulse clearing
// - source strap picks panel or PIO lines
// - data valid low exactly while words valid
module sbe_emitter (
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic                       link_clk,
   input  wire logic                       panel_trig,
   input  wire logic                       panel_rst_pulse,
   input  wire logic                       pio1_in,
   input  wire logic                       pio2_in,
   input  wire logic                       spare_config_strap,
   input  wire logic                       frame_marker_strap,
   input  wire logic                       counter_clear_strap,
   input  wire logic                       source_select_strap,
   input  wire logic [sbe_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [31:0]                reg_rdata,
   output logic      [sbe_pkg::WORD_W-1:0] fpdp_data,
   output logic                            fpdp_dvalid_n,
   output logic                            fpdp_sync_n
);
   import sbe_pkg::*;

   // ==========================================================
   // declarations
   logic [PIN_W-1:0]  pin_s;
   logic              trig_sel, rst_sel, trig_prev_reg, rst_prev_reg;
   logic              trig_edge, rst_edge, capture, count_clear;
   logic              ctrl_en_reg, drop_reg;
   logic [31:0]       count_reg, count_next, status_word;
   logic [WORD_W-1:0] word_reg [BLOCK_WORDS];
   sbe_ref_state_t    rf_state_reg;
   logic [7:0]        wait_reg;
   logic              start_tgl_reg, done_s, done_prev_reg, done_evt;
   logic [1:0]        link_in_s;
   logic [1:0]        link_rst_reg;
   logic              link_rst_n;
   sbe_link_state_t   lk_state_reg;
   logic              start_prev_reg, start_evt, done_tgl_reg;
   logic [IDX_W-1:0]  idx_reg;

   // first word appears one link cycle after the start event lands
   localparam logic [7:0] WAIT_LOAD = 8'(FIRST_WORD_CYC - 1);

   // block word content; header, counter, strap status, then fill
   function automatic logic [WORD_W-1:0] block_word(input int i,
                                                   input logic [31:0] cnt,
                                                   input logic [31:0] st);
      logic [WORD_W-1:0] w;
      w = '0;
      if (i == 0) begin
         w = HEADER_WORD;
      end else if (i == 1) begin
         w = cnt;
      end else if (i == 2) begin
         w = st;
      end else begin
         w = WORD_W'(i);
      end
      return w;
   endfunction : block_word

   // ==========================================================
   // pin synchronisation into ref_clk
   sbe_sync2 #(.W(PIN_W)) u_pin_sync (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .d     ({source_select_strap, counter_clear_strap, frame_marker_strap,
               spare_config_strap, pio2_in, panel_rst_pulse, pio1_in, panel_trig}),
      .q     (pin_s)
   );

   // fitted source strap reads zero: panel connectors, else PIO lines
   assign trig_sel = pin_s[PIN_SRC] ? pin_s[PIN_TRIG_IO] : pin_s[PIN_TRIG_FP];
   assign rst_sel  = pin_s[PIN_SRC] ? pin_s[PIN_RST_IO]  : pin_s[PIN_RST_FP];

   // leading edges of the selected trigger and reset pulse
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_prev_reg <= 1'b0;
         rst_prev_reg  <= 1'b0;
      end else begin
         trig_prev_reg <= trig_sel;
         rst_prev_reg  <= rst_sel;
      end
   end
   assign trig_edge = trig_sel & ~trig_prev_reg;
   assign rst_edge  = rst_sel & ~rst_prev_reg;

   // edges during a block are dropped so the held words stay intact
   assign capture = trig_edge & ctrl_en_reg & (rf_state_reg == RF_IDLE);

   // ==========================================================
   // block counter; fitted clear strap lets the reset pulse clear it
   assign count_clear = (rst_edge & ~pin_s[PIN_CLR])
                        | (reg_wr & (reg_addr == CTRL_OFS) & reg_wdata[CTRL_CLR_BIT]);
   assign count_next  = count_reg + 32'h0000_0001;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 32'h0000_0000;
      end else if (count_clear) begin
         count_reg <= 32'h0000_0000;
      end else if (capture) begin
         count_reg <= count_next;
      end
   end

   // straps as read; open jumper pulled high gives one
   always_comb begin
      status_word               = '0;
      status_word[ST_BUSY_BIT]  = (rf_state_reg != RF_IDLE);
      status_word[ST_SPARE_BIT] = pin_s[PIN_SPARE];
      status_word[ST_FRAME_BIT] = pin_s[PIN_FRAME];
      status_word[ST_CLR_BIT]   = pin_s[PIN_CLR];
      status_word[ST_SRC_BIT]   = pin_s[PIN_SRC];
      status_word[ST_DROP_BIT]  = drop_reg;
   end

   // ==========================================================
   // block capture; words stand until the next accepted trigger
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < BLOCK_WORDS; i++) begin
            word_reg[i] <= '0;
         end
      end else if (capture) begin
         for (int i = 0; i < BLOCK_WORDS; i++) begin
            word_reg[i] <= block_word(i, count_next, status_word);
         end
      end
   end

   // ==========================================================
   // ref-side sequencer: wait the latency, hand off, await completion
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rf_state_reg  <= RF_IDLE;
         wait_reg      <= 8'h00;
         start_tgl_reg <= 1'b0;
      end else begin
         unique case (rf_state_reg)
            RF_IDLE: begin
               if (capture) begin
                  rf_state_reg <= RF_WAIT;
                  wait_reg     <= WAIT_LOAD;
               end
            end
            RF_WAIT: begin
               if (wait_reg == 8'h00) begin
                  start_tgl_reg <= ~start_tgl_reg;
                  rf_state_reg  <= RF_SEND;
               end else begin
                  wait_reg <= wait_reg - 8'h01;
               end
            end
            RF_SEND: begin
               if (done_evt) begin
                  rf_state_reg <= RF_IDLE;
               end
            end
            default: begin
               rf_state_reg <= RF_IDLE;
            end
         endcase
      end
   end

   // completion toggle returns from the link domain
   sbe_sync2 #(.W(1)) u_done_sync (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .d     (done_tgl_reg),
      .q     (done_s)
   );
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_prev_reg <= 1'b0;
      end else begin
         done_prev_reg <= done_s;
      end
   end
   assign done_evt = done_s ^ done_prev_reg;

   // ==========================================================
   // register port: control, status, counter; read data next cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_en_reg <= CTRL_EN_RST;
         drop_reg    <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == CTRL_OFS) begin
            ctrl_en_reg <= reg_wdata[CTRL_EN_BIT];
         end
         // set wins over the write-one clear
         if (trig_edge && rf_state_reg != RF_IDLE) begin
            drop_reg <= 1'b1;
         end else if (reg_wr && reg_addr == STATUS_OFS && reg_wdata[ST_DROP_BIT]) begin
            drop_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            CTRL_OFS:   reg_rdata <= {31'h0000_0000, ctrl_en_reg};
            STATUS_OFS: reg_rdata <= status_word;
            COUNT_OFS:  reg_rdata <= count_reg;
            default:    reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // link domain: local reset release, start toggle and frame strap in
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_rst_reg <= 2'b00;
      end else begin
         link_rst_reg <= {link_rst_reg[0], 1'b1};
      end
   end
   assign link_rst_n = link_rst_reg[1];

   sbe_sync2 #(.W(2)) u_link_sync (
      .clk   (link_clk),
      .rst_n (link_rst_n),
      .d     ({frame_marker_strap, start_tgl_reg}),
      .q     (link_in_s)
   );

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         start_prev_reg <= 1'b0;
      end else begin
         start_prev_reg <= link_in_s[0];
      end
   end
   assign start_evt = link_in_s[0] ^ start_prev_reg;

   // word sender: one word per link clock, data valid low only meanwhile;
   // words are held stable by the ref side until completion returns
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lk_state_reg  <= LK_IDLE;
         idx_reg       <= '0;
         fpdp_data     <= '0;
         fpdp_dvalid_n <= 1'b1;
         fpdp_sync_n   <= 1'b1;
         done_tgl_reg  <= 1'b0;
      end else begin
         unique case (lk_state_reg)
            LK_IDLE: begin
               fpdp_dvalid_n <= 1'b1;
               fpdp_sync_n   <= 1'b1;
               if (start_evt) begin
                  lk_state_reg <= LK_SEND;
                  idx_reg      <= '0;
               end
            end
            LK_SEND: begin
               fpdp_data     <= word_reg[idx_reg];
               fpdp_dvalid_n <= 1'b0;
               fpdp_sync_n   <= ~((idx_reg == LAST_IDX) & ~link_in_s[1]);
               idx_reg       <= idx_reg + 3'h1;
               if (idx_reg == LAST_IDX) begin
                  lk_state_reg <= LK_IDLE;
                  done_tgl_reg <= ~done_tgl_reg;
               end
            end
            default: begin
               lk_state_reg <= LK_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // checks
   sequence s_eight_low;
      !fpdp_dvalid_n [*8];
   endsequence

   chk_latency_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
      capture |-> ##111 $changed(start_tgl_reg))
      else $error("start handoff not at first-word latency");

   chk_block_len: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $fell(fpdp_dvalid_n) |-> s_eight_low ##1 fpdp_dvalid_n)
      else $error("data valid not low for exactly eight words");

   chk_sync_last: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      !fpdp_sync_n |-> !fpdp_dvalid_n ##1 fpdp_dvalid_n)
      else $error("sync marked a word other than the last");

   chk_sync_suppress: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $fell(fpdp_dvalid_n)
      |-> ##7 (fpdp_sync_n == $past(link_in_s[1])))
      else $error("sync on last word disagrees with frame strap");

   chk_words_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rf_state_reg != RF_IDLE) && ($past(rf_state_reg) != RF_IDLE)
      |-> $stable(word_reg[1]) && !capture)
      else $error("block words changed while being sent");

   chk_count_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_edge && !pin_s[PIN_CLR]) |=> count_reg == 32'h0000_0000)
      else $error("reset pulse did not clear counter");

   chk_count_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_edge && pin_s[PIN_CLR] && !count_clear && !capture) |=> $stable(count_reg))
      else $error("counter cleared though strap open");

   chk_source_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!pin_s[PIN_SRC] && $rose(pin_s[PIN_TRIG_IO]) && !$rose(pin_s[PIN_TRIG_FP]))
      |-> !trig_edge)
      else $error("pio trigger used while panel source fitted");

   chk_spare_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == STATUS_OFS) |=> reg_rdata[ST_SPARE_BIT] == $past(pin_s[PIN_SPARE]))
      else $error("spare strap misreported");

   chk_block_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
      capture |-> ##[111:200] rf_state_reg == RF_IDLE)
      else $error("block not finished within trigger period");

endmodule : sbe_emitter

/* File: bench/sbe_fpdp_rx.sv */
// receiver model that stands on the far end of the emitter's word link
// assumes a link clock that is shared with the emitter and data registered on it
module sbe_fpdp_rx (
   input  wire logic        link_clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] data,
   input  wire logic        dvalid_n,
   input  wire logic        sync_n,
   output logic             rx_stb,
   output logic      [31:0] rx_word,
   output logic             rx_sync,
   output logic      [3:0]  rx_idx,
   output logic             blk_end,
   output logic      [3:0]  blk_len
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0] cnt_reg;

   // ======================================================
   // word capture: only a low valid line qualifies the data
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_stb  <= 1'b0;
         rx_word <= 32'h0;
         rx_sync <= 1'b0;
         rx_idx  <= 4'h0;
         blk_end <= 1'b0;
         blk_len <= 4'h0;
         cnt_reg <= 4'h0;
      end else begin
         rx_stb  <= !dvalid_n;
         if (!dvalid_n) begin
            rx_word <= data;
            rx_sync <= !sync_n;
         end
         rx_idx  <= cnt_reg;
         // block ends when valid returns high after at least one word
         blk_end <= dvalid_n && (cnt_reg != 4'h0);
         blk_len <= cnt_reg;
         cnt_reg <= dvalid_n ? 4'h0 : cnt_reg + 4'h1;
      end
   end
endmodule : sbe_fpdp_rx

/* File: bench/tb_sample_block_emitter_timing.sv */
// self-checking bench for the sample block emitter
// assumes the receiver model on the link and straps driven as plain levels
module tb_sample_block_emitter_timing;
   timeunit 1ns;
   timeprecision 100ps;
   import sbe_pkg::*;

   typedef struct { logic [31:0] d; logic [31:0] m; logic s; } sbe_exp_t;

   logic ref_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
   logic panel_trig = 1'b0, panel_rst_pulse = 1'b0, pio1_in = 1'b0, pio2_in = 1'b0;
   logic spare_config_strap = 1'b1, frame_marker_strap = 1'b0;
   logic counter_clear_strap = 1'b1, source_select_strap = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [31:0]       reg_wdata = 32'h0;
   logic              reg_wr = 1'b0, reg_rd = 1'b0, rd_d1 = 1'b0;
   logic [31:0]       reg_rdata, fpdp_data, rx_word, exp_cnt = 32'h0;
   logic              fpdp_dvalid_n, fpdp_sync_n, rx_stb, rx_sync, blk_end, exp_drop = 1'b0;
   logic [3:0]        rx_idx, blk_len;
   int                errors = 0, checks_done = 0, cyc = 0, i;
   real               t_trig, t_first, t_end;
   sbe_exp_t          exp_q[$], w_e;
   logic [31:0]       rd_q[$];

   sbe_emitter u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
      .panel_trig(panel_trig), .panel_rst_pulse(panel_rst_pulse), .pio1_in(pio1_in),
      .pio2_in(pio2_in), .spare_config_strap(spare_config_strap),
      .frame_marker_strap(frame_marker_strap), .counter_clear_strap(counter_clear_strap),
      .source_select_strap(source_select_strap), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fpdp_data(fpdp_data), .fpdp_dvalid_n(fpdp_dvalid_n), .fpdp_sync_n(fpdp_sync_n));

   sbe_fpdp_rx u_rx (.link_clk(link_clk), .rst_n(rst_n), .data(fpdp_data),
      .dvalid_n(fpdp_dvalid_n), .sync_n(fpdp_sync_n), .rx_stb(rx_stb), .rx_word(rx_word),
      .rx_sync(rx_sync), .rx_idx(rx_idx), .blk_end(blk_end), .blk_len(blk_len));

   // ======================================================
   // clocks: link phase offset so the domains never line up
   initial forever #5 ref_clk = ~ref_clk;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end

   // ======================================================
   // shared helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   function automatic logic [31:0] st_exp();
      return {26'h0, exp_drop, source_select_strap, counter_clear_strap,
              frame_marker_strap, spare_config_strap, 1'b0};
   endfunction : st_exp

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      rd_q.push_back(e);
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
   endtask : rd

   // rising edges land exactly gap cycles apart; acc notes the block it must cause
   task automatic trig(input bit pio, input bit acc, input int gap);
      sbe_exp_t e;
      int k;
      @(posedge ref_clk);
      if (pio) pio1_in <= 1'b1;
      else panel_trig <= 1'b1;
      if (acc) begin
         exp_cnt++;
         t_trig = $realtime;
         for (k = 0; k < 8; k++) begin
            e.d = (k == 0) ? HEADER_WORD : (k == 1) ? exp_cnt : (k == 2) ? st_exp() : 32'(k);
            e.m = (k == 2) ? 32'h3e : 32'hffff_ffff;   // busy bit timing left open
            e.s = (k == 7) && !frame_marker_strap;
            exp_q.push_back(e);
         end
      end
      repeat (10) @(posedge ref_clk);
      pio1_in    <= 1'b0;
      panel_trig <= 1'b0;
      repeat (gap - 11) @(posedge ref_clk);
   endtask : trig

   task automatic pulse(input bit pio);
      @(posedge ref_clk);
      if (pio) pio2_in <= 1'b1;
      else panel_rst_pulse <= 1'b1;
      repeat (5) @(posedge ref_clk);
      pio2_in         <= 1'b0;
      panel_rst_pulse <= 1'b0;
      repeat (10) @(posedge ref_clk);
   endtask : pulse

   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 600) begin
         @(posedge ref_clk);
         n++;
      end
      check("block drained", 32'(n < 600), 32'h1);
      repeat (20) @(posedge ref_clk);
   endtask : drain

   // ======================================================
   // watchers: register answers and link words against the notes
   always @(posedge ref_clk) begin
      if (rd_d1) check("reg_rdata", reg_rdata, rd_q.pop_front());
      rd_d1 <= reg_rd;
      cyc++;
      if (cyc == 30000) begin
         errors++;
         tally_and_finish();
      end
   end

   always @(negedge fpdp_dvalid_n) t_first = $realtime;
   always @(posedge fpdp_dvalid_n) t_end = $realtime;

   always @(posedge link_clk) begin
      if (rx_stb && exp_q.size() == 0) check("unexpected word", 32'h1, 32'h0);
      else if (rx_stb) begin
         w_e = exp_q.pop_front();
         check("link word", rx_word & w_e.m, w_e.d & w_e.m);
         check("sync mark", {31'h0, rx_sync}, {31'h0, w_e.s});
         if (rx_idx == 4'h0)
            check("first word delay", 32'((t_first - t_trig) >= 1100.0 && (t_first - t_trig) <= 1200.0), 32'h1);
      end
      if (blk_end) begin
         check("block length", {28'h0, blk_len}, 32'h8);
         check("valid span", 32'((t_end - t_first) > 47.5 && (t_end - t_first) < 48.5), 32'h1);
      end
   end

   // ======================================================
   // main sequence
   initial begin
      void'($urandom(32'h3534882b));
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      // reset values, strap reads and an unmapped place
      rd(CTRL_OFS, {31'h0, CTRL_EN_RST});
      rd(STATUS_OFS, st_exp());
      rd(COUNT_OFS, 32'h0);
      rd(4'hc, 32'h0);
      spare_config_strap <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rd(STATUS_OFS, st_exp());
      // single block, then three at the fastest allowed spacing
      trig(0, 1, 200);
      for (i = 0; i < 3; i++) trig(0, 1, 200);
      drain();
      frame_marker_strap <= 1'b1;
      repeat (10) @(posedge ref_clk);
      trig(0, 1, 200);
      drain();
      // second edge while busy must leave the block intact
      trig(0, 1, 40);
      trig(0, 0, 200);
      exp_drop = 1'b1;
      drain();
      rd(STATUS_OFS, st_exp());
      wr(STATUS_OFS, 32'h20);
      exp_drop = 1'b0;
      rd(STATUS_OFS, st_exp());
      // PIO sources: panel edge ignored, pio edge taken
      source_select_strap <= 1'b1;
      counter_clear_strap <= 1'b0;
      repeat (10) @(posedge ref_clk);
      trig(0, 0, 200);
      trig(1, 1, 200);
      drain();
      pulse(1);
      exp_cnt = 32'h0;
      trig(1, 1, 200);
      counter_clear_strap <= 1'b1;
      drain();
      pulse(1);
      trig(1, 1, 200);
      drain();
      source_select_strap <= 1'b0;
      counter_clear_strap <= 1'b0;
      repeat (10) @(posedge ref_clk);
      pulse(0);
      exp_cnt = 32'h0;
      rd(COUNT_OFS, exp_cnt);
      // panel source fitted: a pio edge must start nothing
      trig(1, 0, 200);
      trig(0, 1, 200);
      drain();
      wr(CTRL_OFS, 32'h3);
      exp_cnt = 32'h0;
      rd(COUNT_OFS, exp_cnt);
      // acceptance disabled: edge ignored, no block
      wr(CTRL_OFS, 32'h0);
      rd(CTRL_OFS, 32'h0);
      trig(0, 0, 200);
      wr(CTRL_OFS, 32'h1);
      // random strap levels and trigger spacing
      for (i = 0; i < 6; i++) begin
         frame_marker_strap <= 1'($urandom_range(0, 1));
         spare_config_strap <= 1'($urandom_range(0, 1));
         repeat (10) @(posedge ref_clk);
         trig(0, 1, 200 + $urandom_range(0, 60));
      end
      drain();
      rd(COUNT_OFS, exp_cnt);
      repeat (5) @(posedge ref_clk);
      tally_and_finish();
   end
endmodule : tb_sample_block_emitter_timing
